// *** logic/external_bus_pin_mux.sv ***
// Pin multiplexer for general ports and the external address/data bus.
`timescale 1ns/1ps
module external_bus_pin_mux
	import pin_mux_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Mode straps and select
	input  wire logic        processor_mode_strap,
	input  wire logic        micro_mode_sel,
	input  wire logic        bus_width_pin,
	input  wire logic        clkout_enable,
	// Core port register access
	input  wire logic [3:0]  port_sel,
	input  wire logic        data_we,
	input  wire logic        dir_we,
	input  wire logic [7:0]  port_wdata,
	output logic      [7:0]  port_rdata,
	// Core bus cycle request
	input  wire logic        bus_req,
	input  wire logic        bus_write,
	input  wire logic        bus_word,
	input  wire logic [23:0] bus_addr,
	input  wire logic [15:0] bus_wdata,
	output logic             bus_done,
	output logic      [15:0] bus_rdata,
	output logic             hold_granted,
	output logic             bus_is_8bit,
	// Peripheral alternate functions
	input  wire logic [3:0]  timer_a_out,
	input  wire logic [3:0]  timer_a_oe,
	input  wire logic [7:0]  uart_out,
	input  wire logic [7:0]  uart_oe,
	output logic      [7:0]  port_five_in,
	output logic      [7:0]  port_six_in,
	output logic      [7:0]  analog_channel_inputs,
	output logic             convert_trigger,
	output logic      [7:0]  port_eight_in,
	// Bus enable strobe pin
	output logic             bus_enable_n,
	// Port pins
	input  wire logic [71:0] pin_in,
	output logic      [71:0] pin_out,
	output logic      [71:0] pin_oe
);

	// All assertions below share this clock and reset.
	default clocking main_cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	proc_mode_type mode_r;
	logic          bus_mode;
	logic          wide_bus;
	logic [71:0]   pin_sync_lvl;
	logic [71:0]   data_all;
	logic [71:0]   dir_all;
	logic [8:0]    data_we_v;
	logic [8:0]    dir_we_v;

	// The strap is caught once after reset release, never under reset.
	logic strap_caught_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r         <= MODE_SINGLE;
			strap_caught_r <= 1'b0;
		end else if (!strap_caught_r) begin
			strap_caught_r <= 1'b1;
			mode_r <= !processor_mode_strap ? MODE_SINGLE :
				(micro_mode_sel ? MODE_MICRO : MODE_EXPANSION);
		end
	end

	assign bus_mode    = (mode_r != MODE_SINGLE);
	assign wide_bus    = bus_mode & ~bus_width_pin;
	assign bus_is_8bit = bus_mode & bus_width_pin;

	// ****************************************************************
	// General ports
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < PORT_COUNT; g++) begin : gen_port
			assign data_we_v[g] = data_we & (port_sel == 4'(g));
			assign dir_we_v[g]  = dir_we & (port_sel == 4'(g));
			gp_port #(.WIDTH(PORT_WIDTH)) u_port (
				.clk    (clk),
				.rst_n  (rst_n),
				.data_we(data_we_v[g]),
				.dir_we (dir_we_v[g]),
				.wdata  (port_wdata),
				.data_r (data_all[g*8 +: 8]),
				.dir_r  (dir_all[g*8 +: 8])
			);
		end
	endgenerate

	pin_sync #(.WIDTH(72)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin_in(pin_in),
		.level (pin_sync_lvl)
	);

	// Input pins read the pin level, output pins read the latch.
	logic [7:0] rd_pin;
	logic [7:0] rd_dat;
	logic [7:0] rd_dir;
	assign rd_pin = (port_sel < 4'(PORT_COUNT)) ?
		pin_sync_lvl[port_sel*8 +: 8] : 8'h00;
	assign rd_dat = (port_sel < 4'(PORT_COUNT)) ?
		data_all[port_sel*8 +: 8] : 8'h00;
	assign rd_dir = (port_sel < 4'(PORT_COUNT)) ?
		dir_all[port_sel*8 +: 8] : 8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_rdata <= 8'h00;
		end else begin
			port_rdata <= (rd_dat & rd_dir) | (rd_pin & ~rd_dir);
		end
	end

	// ****************************************************************
	// Clock output divider
	// ****************************************************************
	logic clk_div_r;
	logic clkout_on;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_div_r <= 1'b0;
		end else begin
			clk_div_r <= ~clk_div_r;
		end
	end
	assign clkout_on = (mode_r == MODE_MICRO) | clkout_enable;

	// ****************************************************************
	// External bus cycle sequencer
	// ****************************************************************
	typedef enum logic [2:0] {
		BS_IDLE  = 3'b000,
		BS_ADDR  = 3'b001,
		BS_LATCH = 3'b010,
		BS_DATA  = 3'b011,
		BS_END   = 3'b100,
		BS_HOLD  = 3'b101
	} bus_state_type;

	bus_state_type state_r;
	bus_state_type state_nxt;
	logic          hold_req;
	logic          ready_in;
	logic [23:0]   addr_r;
	logic [15:0]   wdat_r;
	logic          write_r;
	logic          word_r;
	logic          ale_r;

	assign hold_req = bus_mode & pin_sync_lvl[32 + P4_HOLD];
	assign ready_in = ~bus_mode | pin_sync_lvl[32 + P4_READY];

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			BS_IDLE: begin
				if (hold_req) begin
					state_nxt = BS_HOLD;
				end else if (bus_req & bus_mode) begin
					state_nxt = BS_ADDR;
				end
			end
			BS_ADDR:  state_nxt = BS_LATCH;
			BS_LATCH: state_nxt = BS_DATA;
			BS_DATA: begin
				if (ready_in) begin
					state_nxt = BS_END;
				end
			end
			BS_END:   state_nxt = BS_IDLE;
			BS_HOLD: begin
				if (!hold_req) begin
					state_nxt = BS_IDLE;
				end
			end
			default:  state_nxt = BS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= BS_IDLE;
			addr_r  <= 24'h00_0000;
			wdat_r  <= 16'h0000;
			write_r <= 1'b0;
			word_r  <= 1'b0;
			ale_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ale_r   <= (state_nxt == BS_ADDR);
			if (state_r == BS_IDLE && state_nxt == BS_ADDR) begin
				addr_r  <= bus_addr;
				wdat_r  <= bus_wdata;
				write_r <= bus_write;
				word_r  <= bus_word & wide_bus;
			end
		end
	end

	// Strobe is low only for the data phase of a cycle.
	assign bus_enable_n = ~(state_r == BS_DATA);
	assign bus_done     = (state_r == BS_END);
	assign hold_granted = (state_r == BS_HOLD);

	// Read data are taken as the data phase ends.
	// The memory answers our own strobe, so the data lines skip the filter.
	logic [15:0] rdat_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdat_r <= 16'h0000;
		end else if (state_r == BS_DATA && ready_in && !write_r) begin
			rdat_r[7:0]  <= pin_in[23:16];
			rdat_r[15:8] <= wide_bus ? pin_in[15:8] : 8'h00;
		end
	end
	assign bus_rdata = rdat_r;

	// ****************************************************************
	// Pin drive selection
	// ****************************************************************
	logic        in_data;
	logic        in_cycle;
	logic        drv_bus;
	logic [7:0]  p1_out;
	logic [7:0]  p2_out;
	logic        p1_oe;
	logic        p2_oe;
	logic [7:0]  ctl_bits;

	assign in_data = (state_r == BS_DATA);
	assign in_cycle = ~(state_r == BS_IDLE | hold_granted);
	assign drv_bus = bus_mode & ~hold_granted;
	assign p1_out  = (wide_bus & in_data) ? wdat_r[15:8] : addr_r[15:8];
	assign p1_oe   = drv_bus & ~(wide_bus & in_data & ~write_r);
	assign p2_out  = in_data ? wdat_r[7:0] : addr_r[23:16];
	assign p2_oe   = drv_bus & ~(in_data & ~write_r);

	always_comb begin
		ctl_bits           = 8'h00;
		ctl_bits[CTL_RW]   = ~write_r;
		ctl_bits[CTL_BHE]  = ~(word_r & in_cycle);
		ctl_bits[CTL_ALE]  = ale_r;
		ctl_bits[CTL_HOLD_ACKNOWLEDGE] = ~hold_granted;
	end

	logic [7:0] p4_out;
	logic [7:0] p4_oe;
	logic [7:0] p5_out;
	logic [7:0] p5_oe;
	logic [7:0] p8_out;
	logic [7:0] p8_oe;
	always_comb begin
		p4_out = data_all[39:32];
		p4_oe  = dir_all[39:32];
		if (bus_mode) begin
			p4_oe[P4_HOLD]  = 1'b0;
			p4_oe[P4_READY] = 1'b0;
		end
		if (clkout_on) begin
			p4_out[P4_CLKOUT] = clk_div_r;
			p4_oe[P4_CLKOUT]  = 1'b1;
		end
		p5_out = data_all[47:40];
		p5_oe  = dir_all[47:40];
		p5_out[3:0] = (timer_a_oe & timer_a_out) |
			(~timer_a_oe & data_all[43:40]);
		p5_oe[3:0]  = timer_a_oe | dir_all[43:40];
		p8_out = (uart_oe & uart_out) | (~uart_oe & data_all[71:64]);
		p8_oe  = uart_oe | dir_all[71:64];
	end

	assign pin_out[7:0]   = bus_mode ? addr_r[7:0] : data_all[7:0];
	assign pin_oe[7:0]    = drv_bus ? 8'hFF : dir_all[7:0];
	assign pin_out[15:8]  = bus_mode ? p1_out : data_all[15:8];
	assign pin_oe[15:8]   = bus_mode ? {8{p1_oe}} : dir_all[15:8];
	assign pin_out[23:16] = bus_mode ? p2_out : data_all[23:16];
	assign pin_oe[23:16]  = bus_mode ? {8{p2_oe}} : dir_all[23:16];
	assign pin_out[31:24] = bus_mode ? ctl_bits : data_all[31:24];
	assign pin_oe[31:24]  = bus_mode ? 8'h0F : dir_all[31:24];
	assign pin_out[39:32] = p4_out;
	assign pin_oe[39:32]  = p4_oe;
	assign pin_out[47:40] = p5_out;
	assign pin_oe[47:40]  = p5_oe;
	assign pin_out[63:48] = data_all[63:48];
	assign pin_oe[63:48]  = dir_all[63:48];
	assign pin_out[71:64] = p8_out;
	assign pin_oe[71:64]  = p8_oe;

	// Alternate inputs see the filtered pin levels.
	assign port_five_in          = pin_sync_lvl[47:40];
	assign port_six_in           = pin_sync_lvl[55:48];
	assign analog_channel_inputs = pin_sync_lvl[63:56];
	assign convert_trigger       = pin_sync_lvl[56 + P7_TRIG];
	assign port_eight_in         = pin_sync_lvl[71:64];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence addr_phase_s;
		state_r == BS_ADDR ##1 state_r == BS_LATCH;
	endsequence

	strobe_data_a: assert property (
		!bus_enable_n |-> bus_mode && state_r == BS_DATA)
		else $error("strobe low outside data phase");
	cycle_order_a: assert property (
		addr_phase_s |=> !bus_enable_n)
		else $error("data phase did not follow address phase");
	single_in_a: assert property (
		mode_r == MODE_SINGLE |-> pin_oe[31:0] == dir_all[31:0])
		else $error("single-chip port drive differs from direction");
	reset_in_a: assert property (
		$rose(strap_caught_r) |-> pin_oe[63:48] == 16'h0000)
		else $error("port not input after reset");
	addr_low_a: assert property (
		drv_bus |-> pin_out[7:0] == addr_r[7:0] && pin_oe[7:0] == 8'hFF)
		else $error("port zero not address");
	narrow_p1_a: assert property (
		bus_mode && bus_width_pin |-> pin_out[15:8] == addr_r[15:8])
		else $error("narrow bus port one carried data");
	p2_addr_a: assert property (
		bus_mode && bus_enable_n |-> pin_out[23:16] == addr_r[23:16])
		else $error("port two not address while strobe high");
	micro_clk_a: assert property (
		mode_r == MODE_MICRO |-> pin_oe[34] ##1
		pin_out[34] != $past(pin_out[34]))
		else $error("clock output not toggling in microprocessor mode");

endmodule

// *** logic/gp_port.sv ***
// One general 8-bit bidirectional port with data and direction registers.
`timescale 1ns/1ps
module gp_port
	import pin_mux_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Core access
	input  wire logic             data_we,
	input  wire logic             dir_we,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] data_r,
	output logic      [WIDTH-1:0] dir_r
);

	// The core writes one byte per port, so other widths are refused.
	if (WIDTH != PORT_WIDTH) begin : gen_bad_width
		$error("gp_port width must be eight");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_r <= DATA_RESET;
			dir_r  <= DIR_RESET;
		end else begin
			if (data_we) begin
				data_r <= wdata;
			end
			if (dir_we) begin
				dir_r <= wdata;
			end
		end
	end

endmodule

// *** logic/pin_mux_pkg.sv ***
// Package of constants shared by the external bus pin multiplexer.
package pin_mux_pkg;

	// ****************************************************************
	// Port geometry
	// ****************************************************************
	localparam int PORT_WIDTH  = 8;
	localparam int PORT_COUNT  = 9;
	localparam int SYNC_STAGES = 3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] DIR_RESET  = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ****************************************************************
	// Field positions on the control port, port four and port seven
	// ****************************************************************
	localparam int CTL_RW    = 0;
	localparam int CTL_BHE   = 1;
	localparam int CTL_ALE   = 2;
	localparam int CTL_HOLD_ACKNOWLEDGE  = 3;
	localparam int P4_HOLD   = 0;
	localparam int P4_READY  = 1;
	localparam int P4_CLKOUT = 2;
	localparam int P7_TRIG   = 7;

	// ****************************************************************
	// Timing counts
	// ****************************************************************
	localparam int CLK_DIVIDE = 2;

	// ****************************************************************
	// Processor modes
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_SINGLE    = 2'b00,
		MODE_EXPANSION = 2'b01,
		MODE_MICRO     = 2'b10
	} proc_mode_type;

endpackage

// *** logic/pin_sync.sv ***
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module pin_sync
	import pin_mux_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Pin sample and filtered result
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] level_nxt;

	if (WIDTH < 1) begin : gen_bad_width
		$error("pin_sync needs at least one bit");
	end

	// A bit changes only once stages two and three agree.
	assign level_nxt = (s2_r & s3_r) | (level & (s2_r | s3_r));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			level <= '0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			level <= level_nxt;
		end
	end

endmodule

// *** sim/ext_mem_model.sv ***
// External memory on the multiplexed address/data bus.
`timescale 1ns/1ps
module ext_mem_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Device pins seen from the bus
	input  wire logic [71:0] pin_out,
	input  wire logic [71:0] pin_oe,
	input  wire logic        bus_enable_n,
	// Test controls
	input  wire logic        slow,
	input  wire logic [3:0]  wait_n,
	input  wire logic        hold_req,
	// Levels driven back onto the pins
	output logic      [15:0] dq_in,
	output logic      [1:0]  p4_in
);
	logic [23:0] addr_r;
	logic [15:0] wr_r;
	logic [15:0] last_r;
	logic [3:0]  cnt_r;
	logic        ale_r;
	logic        bhe_r;
	logic        rd_r;
	logic        ale;
	logic        rd;

	assign ale = pin_out[26];
	assign rd  = pin_out[24];

	// ****************************************************************
	// Address latch, write capture and read drive
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_r <= 24'h00_0000;
			wr_r   <= 16'h0000;
			last_r <= 16'h0000;
			cnt_r  <= 4'h0;
			ale_r  <= 1'b0;
			bhe_r  <= 1'b1;
			rd_r   <= 1'b1;
		end else begin
			ale_r <= ale;
			if (ale_r && !ale && bus_enable_n) begin
				addr_r <= pin_out[23:0];
				bhe_r  <= pin_out[25];
				rd_r   <= rd;
			end
			if (!bus_enable_n && !rd_r)
				wr_r <= {pin_out[15:8], pin_out[23:16]};
			cnt_r  <= bus_enable_n ? 4'h0 : cnt_r + 4'h1;
			last_r <= dq_in;
		end
	end

	// Released lines show a changing pattern, never the old data.
	// The memory drives only once the device has let go of the data lines.
	assign dq_in = (!bus_enable_n && rd_r && !pin_oe[16]) ?
		{addr_r[15:8] ^ 8'hA5, addr_r[7:0] ^ 8'h5A} : ~last_r;
	assign p4_in = {!slow || cnt_r >= wait_n, hold_req};
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the pin multiplexer and external bus.
`timescale 1ns/1ps
module tb_top;
	import pin_mux_pkg::*;
	logic        clk, rst_n, strap, micro, width, clken;
	logic        dwe, rwe, req, bwr, bwd, done, hgr, b8, trig, ben_n;
	logic        slow, hold;
	logic [3:0]  sel, ta_out, ta_oe, wait_n;
	logic [7:0]  wdat, rdat, u_out, u_oe, in5, in6, an, in8, oe1, out1;
	logic [23:0] addr;
	logic [15:0] bwdat, brd, dq_in;
	logic [1:0]  p4_in;
	logic [71:0] tb_pins, pin_in, pin_out, pin_oe;
	int          failures, checks_done, n_cyc, hits;

	assign pin_in = strap ? {tb_pins[71:34], p4_in, tb_pins[31:24],
		dq_in[7:0], dq_in[15:8], tb_pins[7:0]} : tb_pins;

	external_bus_pin_mux u_dut (.clk(clk), .rst_n(rst_n),
		.processor_mode_strap(strap), .micro_mode_sel(micro),
		.bus_width_pin(width), .clkout_enable(clken), .port_sel(sel),
		.data_we(dwe), .dir_we(rwe), .port_wdata(wdat), .port_rdata(rdat),
		.bus_req(req), .bus_write(bwr), .bus_word(bwd), .bus_addr(addr),
		.bus_wdata(bwdat), .bus_done(done), .bus_rdata(brd),
		.hold_granted(hgr), .bus_is_8bit(b8), .timer_a_out(ta_out),
		.timer_a_oe(ta_oe), .uart_out(u_out), .uart_oe(u_oe),
		.port_five_in(in5), .port_six_in(in6), .analog_channel_inputs(an),
		.convert_trigger(trig), .port_eight_in(in8),
		.bus_enable_n(ben_n), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe));

	ext_mem_model u_mem (.clk(clk), .rst_n(rst_n), .pin_out(pin_out),
		.pin_oe(pin_oe), .bus_enable_n(ben_n), .slow(slow),
		.wait_n(wait_n), .hold_req(hold), .dq_in(dq_in), .p4_in(p4_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic do_reset(input logic s, input logic m);
		@(negedge clk);
		rst_n = 1'b0;
		strap = s;
		micro = m;
		cyc(2);
		rst_n = 1'b1;
		cyc(2);
	endtask

	task automatic pw(input int p, input logic [7:0] d, input logic [7:0] v);
		sel = 4'(p);
		wdat = d;
		rwe = 1'b1;
		cyc(1);
		rwe = 1'b0;
		dwe = 1'b1;
		wdat = v;
		cyc(1);
		dwe = 1'b0;
	endtask

	task automatic bus_op(input logic w, input logic wd,
			input logic [23:0] a, input logic [15:0] d);
		bwr = w;
		bwd = wd;
		addr = a;
		bwdat = d;
		req = 1'b1;
		cyc(1);
		req = 1'b0;
		n_cyc = 1;
		while (done !== 1'b1 && n_cyc < 40) begin
			if (ben_n === 1'b0) begin
				oe1 = pin_oe[15:8];
				out1 = pin_out[15:8];
			end
			cyc(1);
			n_cyc++;
		end
		// Let the sequencer return to idle so the next request is taken.
		cyc(1);
		if (n_cyc >= 40) begin
			failures++;
			final_report();
		end
	endtask

	// Pulse a request and count strobe-low and done cycles after it.
	task automatic refused;
		req = 1'b1;
		cyc(1);
		req = 1'b0;
		hits = 0;
		repeat (10) begin
			cyc(1);
			hits += int'(done !== 1'b0) + int'(ben_n !== 1'b1);
		end
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		{rst_n, strap, micro, width, clken, dwe, rwe, req} = '0;
		{bwr, bwd, slow, hold, sel, ta_out, ta_oe, wait_n} = '0;
		{wdat, u_out, u_oe, addr, bwdat} = '0;
		tb_pins = '0;
		failures = 0;
		checks_done = 0;
		do_reset(1'b0, 1'b0);
		for (int i = 0; i < 3; i++)
			check(pin_oe[i*24 +: 24], 24'h0);
		refused();
		check(24'(hits), 24'h0);
		for (int p = 0; p < 9; p++) begin
			pw(p, 8'hF0, 8'hA5);
			tb_pins[p*8 +: 8] = 8'h3C;
			cyc(5);
			check(24'(pin_oe[p*8 +: 8]), 24'hF0);
			check(24'(pin_out[p*8 +: 8] & 8'hF0), 24'hA0);
			check(24'(rdat), 24'hAC);
		end
		sel = 4'h9;
		cyc(2);
		check(24'(rdat), 24'h0);
		check({in5, in6, an}, 24'h3C_3C3C);
		check(24'(in8), 24'h3C);
		tb_pins[63:56] = 8'h80;
		cyc(5);
		check(24'(trig), 24'h1);
		{ta_out, ta_oe, u_out, u_oe} = {4'h9, 4'hF, 8'h5A, 8'hFF};
		cyc(2);
		check({pin_oe[43:40], pin_out[43:40]}, 24'hF9);
		check({pin_oe[71:64], pin_out[71:64]}, 24'hFF5A);
		{ta_oe, u_oe} = '0;
		clken = 1'b1;
		cyc(3);
		check(24'(pin_oe[34]), 24'h1);
		oe1[0] = pin_out[34];
		cyc(1);
		check(24'(pin_out[34]), 24'(!oe1[0]));
		$display("Test single-chip ports done");

		clken = 1'b0;
		do_reset(1'b1, 1'b1);
		check(24'(pin_oe[34]), 24'h1);
		oe1[0] = pin_out[34];
		cyc(1);
		check(24'(pin_out[34]), 24'(!oe1[0]));
		check({pin_oe[7:0], 4'h0, pin_oe[27:24]}, 24'hFF0F);
		check(24'(b8), 24'h0);
		bus_op(1'b0, 1'b1, 24'h12_3456, 16'h0000);
		check(u_mem.addr_r, 24'h12_3456);
		check(24'(brd), 24'h910C);
		check({u_mem.rd_r, u_mem.bhe_r}, 24'h2);
		bus_op(1'b1, 1'b1, 24'hAB_CDEF, 16'hBEEF);
		check(24'(u_mem.wr_r), 24'hBEEF);
		check(24'(u_mem.rd_r), 24'h0);
		$display("Test wide bus done");

		width = 1'b1;
		cyc(2);
		check(24'(b8), 24'h1);
		bus_op(1'b0, 1'b0, 24'h00_7788, 16'h0000);
		check({oe1, out1}, 24'hFF77);
		check(24'(brd[7:0]), 24'hD2);
		$display("Test narrow bus done");

		width = 1'b0;
		slow = 1'b1;
		wait_n = 4'h6;
		cyc(6);
		bus_op(1'b0, 1'b1, 24'h00_0102, 16'h0000);
		check(24'(n_cyc >= 10), 24'h1);
		check(24'(brd), 24'hA458);
		slow = 1'b0;
		hold = 1'b1;
		cyc(6);
		check({hgr, pin_out[27]}, 24'h2);
		refused();
		check(24'(hits), 24'h0);
		hold = 1'b0;
		cyc(6);
		check(24'(hgr), 24'h0);
		$display("Test ready and hold done");

		do_reset(1'b1, 1'b0);
		check({pin_oe[34], pin_oe[7:0]}, 24'h0FF);
		bus_op(1'b0, 1'b1, 24'h00_0304, 16'h0000);
		check(24'(brd), 24'hA65E);
		clken = 1'b1;
		cyc(1);
		check(24'(pin_oe[34]), 24'h1);
		$display("Test expansion mode done");
		final_report();
	end
endmodule
